// [vpg_pkg.sv]
package vpg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [9:0] ADDR_SELFTEST = 10'h00d;
  localparam logic [9:0] ADDR_FORMAT_A = 10'h00c;
  localparam int CODE_LSB = 0;
  localparam int CODE_W = 6;
  localparam int RUN_BIT = 6;
  localparam int PASS_BIT = 7;
  localparam int SMOOTH_BIT = 0;
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ****************************************
  // pattern code fields
  // ****************************************
  localparam int HD_BIT = 5;
  localparam int PAL_BIT = 4;
  localparam logic [1:0] PAT_BLACK = 2'h0;
  localparam logic [1:0] PAT_PLL = 2'h1;
  localparam logic [1:0] PAT_EQ = 2'h2;
  localparam logic [1:0] PAT_BARS = 2'h3;
  localparam logic [5:0] SD_NTSC_BARS = 6'h03;
  localparam logic [5:0] SD_PAL_PLL = 6'h11;

  // ****************************************
  // levels and checking
  // ****************************************
  localparam logic [9:0] BLACK_Y = 10'h040;
  localparam logic [9:0] MID_C = 10'h200;
  localparam logic [9:0] PATH_C = 10'h300;
  localparam logic [9:0] EQ_Y = 10'h198;
  localparam logic [9:0] PLL_Y = 10'h110;
  localparam logic [7:0][9:0] BAR_Y = {10'h040, 10'h08f, 10'h108, 10'h14f,
    10'h1c2, 10'h20d, 10'h286, 10'h2d1};
  localparam logic [7:0][9:0] BAR_CB = {10'h200, 10'h350, 10'h18f, 10'h2df,
    10'h121, 10'h271, 10'h0b0, 10'h200};
  localparam logic [7:0][9:0] BAR_CR = {10'h200, 10'h1c9, 10'h350, 10'h317,
    10'h0e7, 10'h0b0, 10'h237, 10'h200};
  localparam logic [15:0] CRC_POLY = 16'h1041;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [1:0] INIT_EDGES = 2'h3;
  localparam logic [1:0] PASS_FIELDS = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic clk;
    logic selN;
    logic rdWr;
    logic [9:0] ad;
  } vpg_aux_t;

  typedef struct packed {
    logic tag;
    logic [9:0] word;
  } vpg_word_t;

endpackage : vpg_pkg

// [vpg_fifo.sv]
`timescale 1ns/1ps
module vpg_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  input logic clk, // system clock
  input logic rst, // async reset, high
  input logic flush, // drop all content
  input logic inValid, // write request
  output logic inReady, // room for a word
  input logic [WIDTH-1:0] inData, // word in
  output logic outValid, // word available
  input logic outReady, // reader takes word
  output logic [WIDTH-1:0] outData // word out
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } vpg_fifo_state_t;

  vpg_fifo_state_t st_reg, st_next;
  logic push, pop;

  // handshakes from the fill level
  assign inReady = (st_reg.count != (AW+1)'(DEPTH));
  assign outValid = (st_reg.count != '0);
  assign outData = st_reg.mem[st_reg.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // pointer and storage update
  always_comb begin
    st_next = st_reg;
    if (flush) begin
      st_next.wrPtr = '0;
      st_next.rdPtr = '0;
      st_next.count = '0;
    end else begin
      if (push) begin
        st_next.mem[st_reg.wrPtr] = inData;
        st_next.wrPtr = st_reg.wrPtr + 1'b1;
      end
      if (pop) st_next.rdPtr = st_reg.rdPtr + 1'b1;
      if (push && !pop) st_next.count = st_reg.count + 1'b1;
      else if (pop && !push) st_next.count = st_reg.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) st_reg <= '0;
    else st_reg <= st_next;
  end

endmodule : vpg_fifo

// [vpg_self_test.sv]
`timescale 1ns/1ps
module vpg_self_test #(
  parameter int LINE_WORDS = 1716,
  parameter int FIELD_LINES = 262,
  parameter int FIFO_DEPTH = 32
) (
  input logic clk, // system clock
  input logic rst, // async reset, high
  input logic auxClk, // aux port clock pin
  input logic auxSelectN, // aux port select, low for control
  input logic auxRdWr, // high read, low write
  input logic [9:0] adIn, // aux bus pin level
  output logic [9:0] adOut, // aux bus read data
  output logic adOe, // aux bus driven by device
  input logic runPin, // I/O bit 7 run input
  input logic runPinMapped, // run still on its I/O pin
  output logic passOut, // I/O bit 6 result
  input logic [9:0] parallelData, // external video word
  input logic parallelValid, // external word present
  output logic parallelReady, // external word taken
  output logic [9:0] serialWord, // word to serializer
  output logic serialValid, // serializer word present
  input logic serialReady // serializer takes word
);
  // counter end points
  localparam int BAR_WORDS = LINE_WORDS / 8;
  localparam int FIELD_WORDS = LINE_WORDS * FIELD_LINES;
  localparam logic [10:0] LAST_WORD = 11'(LINE_WORDS - 1);
  localparam logic [8:0] LAST_LINE = 9'(FIELD_LINES - 1);
  localparam logic [7:0] LAST_BAR = 8'(BAR_WORDS - 1);
  localparam logic [19:0] LAST_FIELD = 20'(FIELD_WORDS - 1);
  localparam logic [2:0] LAST_BAR_IDX = 3'h7; // eighth bar holds any remainder
  localparam int WORD_BITS = 10;

  // refuse geometries the counters cannot hold
  initial begin
    if (FIFO_DEPTH < 2) $error("fifo too shallow");
    if (LINE_WORDS < 16 || LINE_WORDS > 2047) $error("bad line length");
    if (FIELD_LINES < 1 || FIELD_LINES > 511) $error("bad field length");
    if (BAR_WORDS > 255) $error("bar too wide");
    if (FIELD_WORDS <= 2 * FIFO_DEPTH || FIELD_WORDS > 1048575) $error("bad field size");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    vpg_pkg::vpg_aux_t auxS1;
    vpg_pkg::vpg_aux_t auxS2;
    vpg_pkg::vpg_aux_t auxS3;
    vpg_pkg::vpg_aux_t auxQ;
    logic runS1;
    logic runS2;
    logic runS3;
    logic runQ;
    logic [1:0] initCnt;
    logic dataPhase;
    logic [9:0] addr;
    logic [5:0] code;
    logic regRun;
    logic smooth;
    logic [9:0] adOut;
    logic adOe;
    logic runD;
    logic [10:0] wordCnt;
    logic [7:0] barCnt;
    logic [2:0] barIdx;
    logic [8:0] lineCnt;
    logic [9:0] prevY;
    logic [9:0] prevCb;
    logic [9:0] prevCr;
    logic [15:0] genCrc;
    logic [15:0] fieldCrc;
    logic [19:0] outCnt;
    logic [15:0] outCrc;
    logic [1:0] fieldsOk;
    logic err;
    logic pass;
  } vpg_state_t;

  vpg_state_t st_reg, st_next;

  // ****************************************
  // functions
  // ****************************************
  // one 10-bit word into the check word
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [9:0] w);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < WORD_BITS; i++) begin
      if (c[15] ^ w[i]) c = {c[14:0], 1'b0} ^ vpg_pkg::CRC_POLY;
      else c = {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_step

  // mean of two levels
  function automatic logic [9:0] avg10(input logic [9:0] a, input logic [9:0] b);
    logic [10:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[10:1];
  endfunction : avg10

  // ****************************************
  // pattern words
  // ****************************************
  // pattern and path nets
  logic [1:0] patType;
  logic isLuma, isCr, runEff, runRise, accepted, barEdge;
  logic [9:0] rawWord, genWord;
  logic fifoInReady, fifoInValid, fifoOutValid, pop, genPush, extPush;
  vpg_pkg::vpg_word_t fifoIn, fifoOut;

  assign patType = st_reg.code[1:0];
  assign isLuma = st_reg.wordCnt[0];
  assign isCr = st_reg.wordCnt[1];
  assign barEdge = (st_reg.barCnt == '0) && (st_reg.barIdx != '0);

  // raw word for the selected pattern type
  always_comb begin
    case (patType)
      vpg_pkg::PAT_BLACK: rawWord = isLuma ? vpg_pkg::BLACK_Y : vpg_pkg::MID_C;
      vpg_pkg::PAT_PLL: rawWord = isLuma ? vpg_pkg::PLL_Y : vpg_pkg::MID_C;
      vpg_pkg::PAT_EQ: rawWord = isLuma ? vpg_pkg::EQ_Y : vpg_pkg::PATH_C;
      default: begin
        if (isLuma) rawWord = vpg_pkg::BAR_Y[st_reg.barIdx];
        else if (isCr) rawWord = vpg_pkg::BAR_CR[st_reg.barIdx];
        else rawWord = vpg_pkg::BAR_CB[st_reg.barIdx];
      end
    endcase
  end

  // band limit on the first word after a bar change
  always_comb begin
    genWord = rawWord;
    if (st_reg.smooth && patType == vpg_pkg::PAT_BARS && barEdge) begin
      if (isLuma) genWord = avg10(st_reg.prevY, rawWord);
      else if (isCr) genWord = avg10(st_reg.prevCr, rawWord);
      else genWord = avg10(st_reg.prevCb, rawWord);
    end
  end

  // ****************************************
  // run control and data path select
  // ****************************************
  assign runEff = runPinMapped ? st_reg.runQ : st_reg.regRun;
  assign runRise = runEff && !st_reg.runD;
  assign genPush = runEff && fifoInReady && !runRise;
  assign extPush = !runEff && parallelValid;
  assign parallelReady = !runEff && fifoInReady;
  assign fifoInValid = genPush || extPush;
  assign fifoIn.tag = genPush;
  assign fifoIn.word = genPush ? genWord : parallelData;
  assign pop = fifoOutValid && serialReady;
  assign serialValid = fifoOutValid;
  assign serialWord = fifoOut.word;

  // accepted test patterns
  always_comb begin
    if (st_reg.code[vpg_pkg::HD_BIT]) accepted = (patType == vpg_pkg::PAT_BARS);
    else accepted = (st_reg.code == vpg_pkg::SD_NTSC_BARS) || (st_reg.code == vpg_pkg::SD_PAL_PLL);
  end

  // elastic buffer between source and serializer
  vpg_fifo #(
    .WIDTH(11),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(runRise),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(serialReady),
    .outData(fifoOut)
  );

  // ****************************************
  // next state
  // ****************************************
  logic auxEdge;
  logic [7:0] readData;

  // port clock rise seen on the filtered pins
  assign auxEdge = st_reg.auxQ.clk == 1'b0 && st_reg.auxS2.clk && st_reg.auxS3.clk;

  // register read value for the latched address
  always_comb begin
    if (st_reg.addr == vpg_pkg::ADDR_SELFTEST) readData = {st_reg.pass, st_reg.regRun, st_reg.code};
    else if (st_reg.addr == vpg_pkg::ADDR_FORMAT_A) readData = {7'h00, st_reg.smooth};
    else readData = vpg_pkg::READ_ZERO;
  end

  // port, run control, generator and checker next state
  always_comb begin
    st_next = st_reg;
    // pin synchronisers, change taken when stages two and three agree
    st_next.auxS1 = '{clk: auxClk, selN: auxSelectN, rdWr: auxRdWr, ad: adIn};
    st_next.auxS2 = st_reg.auxS1;
    st_next.auxS3 = st_reg.auxS2;
    // clock, select, direction and bus each settle on their own, so a busy bus cannot hold back the clock
    if (st_reg.auxS2.clk == st_reg.auxS3.clk) st_next.auxQ.clk = st_reg.auxS3.clk;
    if (st_reg.auxS2.selN == st_reg.auxS3.selN) st_next.auxQ.selN = st_reg.auxS3.selN;
    if (st_reg.auxS2.rdWr == st_reg.auxS3.rdWr) st_next.auxQ.rdWr = st_reg.auxS3.rdWr;
    if (st_reg.auxS2.ad == st_reg.auxS3.ad) st_next.auxQ.ad = st_reg.auxS3.ad;
    st_next.runS1 = runPin;
    st_next.runS2 = st_reg.runS1;
    st_next.runS3 = st_reg.runS2;
    if (st_reg.runS2 == st_reg.runS3) st_next.runQ = st_reg.runS3;
    // aux port: three idle clocks, then address and data cycles
    if (auxEdge) begin
      if (st_reg.initCnt != vpg_pkg::INIT_EDGES) begin
        st_next.initCnt = st_reg.initCnt + 1'b1;
      end else if (!st_reg.auxS3.selN) begin
        // first edge latches the address, the next one carries data
        if (!st_reg.dataPhase) begin
          st_next.addr = st_reg.auxS3.ad;
          st_next.dataPhase = 1'b1;
        end else begin
          // data phase: only a write changes a register
          st_next.dataPhase = 1'b0;
          if (!st_reg.auxS3.rdWr) begin
            if (st_reg.addr == vpg_pkg::ADDR_SELFTEST) begin
              st_next.code = st_reg.auxS3.ad[vpg_pkg::CODE_LSB +: vpg_pkg::CODE_W];
              st_next.regRun = st_reg.auxS3.ad[vpg_pkg::RUN_BIT];
            end else if (st_reg.addr == vpg_pkg::ADDR_FORMAT_A) begin
              st_next.smooth = st_reg.auxS3.ad[vpg_pkg::SMOOTH_BIT];
            end
          end
        end
      end
    end
    // read data driven during the data phase of a read
    st_next.adOe = st_reg.dataPhase && st_reg.auxQ.rdWr && !st_reg.auxQ.selN;
    st_next.adOut = {2'b00, readData};
    // generator counters, restart on each run start
    st_next.runD = runEff;
    if (runRise) begin
      st_next.wordCnt = '0;
      st_next.barCnt = '0;
      st_next.barIdx = '0;
      st_next.lineCnt = '0;
      st_next.genCrc = vpg_pkg::CRC_INIT;
      st_next.outCrc = vpg_pkg::CRC_INIT;
      st_next.outCnt = '0;
      st_next.fieldsOk = '0;
      st_next.err = 1'b0;
      st_next.pass = 1'b0;
      st_next.prevY = '0; // smoothing history starts clean on every run
      st_next.prevCb = '0;
      st_next.prevCr = '0;
    end else if (genPush) begin
      // remember the last word of each component for smoothing
      if (isLuma) st_next.prevY = genWord;
      else if (isCr) st_next.prevCr = genWord;
      else st_next.prevCb = genWord;
      // end of line: back to the first bar
      if (st_reg.wordCnt == LAST_WORD) begin
        st_next.wordCnt = '0;
        st_next.barCnt = '0;
        st_next.barIdx = '0;
        st_next.lineCnt = (st_reg.lineCnt == LAST_LINE) ? 9'h000 : st_reg.lineCnt + 1'b1;
      end else begin
        // inside a line: step through the bars
        st_next.wordCnt = st_reg.wordCnt + 1'b1;
        if (st_reg.barCnt == LAST_BAR) begin
          st_next.barCnt = '0;
          if (st_reg.barIdx != LAST_BAR_IDX) st_next.barIdx = st_reg.barIdx + 1'b1;
        end else begin
          st_next.barCnt = st_reg.barCnt + 1'b1;
        end
      end
      // sending-side check word, latched per field
      if (st_reg.wordCnt == LAST_WORD && st_reg.lineCnt == LAST_LINE) begin
        st_next.fieldCrc = crc_step(st_reg.genCrc, genWord);
        st_next.genCrc = vpg_pkg::CRC_INIT;
      end else begin
        st_next.genCrc = crc_step(st_reg.genCrc, genWord);
      end
    end
    // receiving-side check word over words leaving the path
    if (!runRise && runEff && pop && fifoOut.tag) begin
      // field complete: compare with the sender's word
      if (st_reg.outCnt == LAST_FIELD) begin
        st_next.outCnt = '0;
        st_next.outCrc = vpg_pkg::CRC_INIT;
        if (crc_step(st_reg.outCrc, fifoOut.word) != st_reg.fieldCrc) begin
          st_next.err = 1'b1;
        end else if (st_reg.fieldsOk != vpg_pkg::PASS_FIELDS) begin
          st_next.fieldsOk = st_reg.fieldsOk + 1'b1;
        end
      end else begin
        // mid-field: keep folding words in
        st_next.outCnt = st_reg.outCnt + 1'b1;
        st_next.outCrc = crc_step(st_reg.outCrc, fifoOut.word);
      end
    end
    // result after two clean fields of an accepted pattern
    if (!runRise && !st_reg.err && accepted && st_reg.fieldsOk == vpg_pkg::PASS_FIELDS) begin
      st_next.pass = 1'b1;
    end
  end

  // ****************************************
  // registers and outputs
  // ****************************************
  // reset leaves code 00h, run and smoothing off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.code <= vpg_pkg::CODE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign adOut = st_reg.adOut;
  assign adOe = st_reg.adOe;
  assign passOut = st_reg.pass;

endmodule : vpg_self_test

// [vpg_self_test_props.sv]
`timescale 1ns/1ps
module vpg_self_test_props (
  input logic clk, // system clock
  input logic rst, // async reset
  input logic auxSelectN, // aux select
  input logic auxRdWr, // aux direction
  input logic adOe, // aux bus driven
  input logic runPin, // run pin
  input logic runPinMapped, // run on pin
  input logic passOut, // result pin
  input logic parallelReady, // video word taken
  input logic [9:0] serialWord, // serial word
  input logic serialValid, // serial word present
  input logic serialReady // serial word taken
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ******
  // properties
  // ******
  // outputs quiet at release, run and pass tied to the pins
  property p_reset_quiet; $fell(rst) |-> !adOe && !passOut && !serialValid; endproperty
  property p_pin_run; runPinMapped && runPin [*8] |-> !parallelReady; endproperty
  property p_pin_low; runPinMapped && !runPin && !serialValid [*8] |-> parallelReady; endproperty
  property p_pass_rise; $rose(passOut) |-> !parallelReady; endproperty
  property p_pass_clear; runPinMapped && $rose(runPin) |-> ##[1:8] !passOut; endproperty
  property p_serial_hold; serialValid && !serialReady |=> serialValid && $stable(serialWord); endproperty
  property p_oe_rise; $rose(adOe) |-> auxRdWr && !auxSelectN; endproperty
  property p_oe_drop; $rose(auxSelectN) |-> ##[1:10] !adOe; endproperty
  property p_run_feeds; runPinMapped && runPin && serialReady [*8] |-> ##[0:4] serialValid; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  a_pin_run: assert property (p_pin_run) else $error("video input taken while running");
  a_pin_low: assert property (p_pin_low) else $error("video input refused while stopped");
  a_pass_rise: assert property (p_pass_rise) else $error("pass set while stopped");
  a_pass_clear: assert property (p_pass_clear) else $error("pass kept over a new run");
  a_serial_hold: assert property (p_serial_hold) else $error("serial word changed while stalled");
  a_oe_rise: assert property (p_oe_rise) else $error("bus driven without a read");
  a_oe_drop: assert property (p_oe_drop) else $error("bus kept after deselect");
  a_run_feeds: assert property (p_run_feeds) else $error("no pattern words while running");
  // main scenarios reached
  c_pass: cover property ($rose(passOut));
  c_read: cover property ($rose(adOe));
  c_stall: cover property (serialValid && !serialReady [*4]);
endmodule : vpg_self_test_props

bind vpg_self_test vpg_self_test_props chk (.clk(clk), .rst(rst), .auxSelectN(auxSelectN), .auxRdWr(auxRdWr),
  .adOe(adOe), .runPin(runPin), .runPinMapped(runPinMapped), .passOut(passOut), .parallelReady(parallelReady),
  .serialWord(serialWord), .serialValid(serialValid), .serialReady(serialReady));

// [vpg_host_model.sv]
`timescale 1ns/1ps
module vpg_host_model (
  input logic clk, // system clock
  output logic auxClk, // aux port clock
  output logic auxSelectN, // low selects control space
  output logic auxRdWr, // high read
  output logic [9:0] adDrive, // bus value from host
  output logic adDriveEn, // host drives bus
  input logic [9:0] adWire // resolved bus level
);
  localparam int HOLD = 8;
  // idle levels: port clock stands low outside transfers
  initial begin
    auxClk = 1'b0;
    auxSelectN = 1'b1;
    auxRdWr = 1'b0;
    adDrive = 10'h000;
    adDriveEn = 1'b0;
  end
  // ******
  // bus cycles
  // ******
  // hold each level, then move the port clock just after an edge
  task automatic tick(input logic lvl);
    repeat (HOLD) @(posedge clk);
    #1 auxClk = lvl;
  endtask : tick
  // three port clocks before the first address
  task automatic aux_init;
    repeat (3) begin
      tick(1'b1);
      tick(1'b0);
    end
  endtask : aux_init
  // address cycle, then data cycle
  task automatic reg_write(input logic [9:0] addr, input logic [9:0] data);
    @(posedge clk);
    #1 auxSelectN = 1'b0;
    auxRdWr = 1'b0;
    adDrive = addr;
    adDriveEn = 1'b1;
    tick(1'b1);
    tick(1'b0);
    adDrive = data;
    tick(1'b1);
    tick(1'b0);
    auxSelectN = 1'b1;
    adDriveEn = 1'b0;
  endtask : reg_write
  // address cycle, bus released, answer taken before the data edge
  task automatic reg_read(input logic [9:0] addr, output logic [7:0] data);
    @(posedge clk);
    #1 auxSelectN = 1'b0;
    auxRdWr = 1'b1;
    adDrive = addr;
    adDriveEn = 1'b1;
    tick(1'b1);
    tick(1'b0);
    adDriveEn = 1'b0;
    repeat (HOLD) @(posedge clk);
    data = adWire[7:0];
    tick(1'b1);
    tick(1'b0);
    auxSelectN = 1'b1;
    auxRdWr = 1'b0;
  endtask : reg_read
endmodule : vpg_host_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  localparam int LIM = 3000;
  localparam int LW = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic auxClk, auxSelectN, auxRdWr, hostEn, adOe, runPin, runPinMapped, passOut;
  logic parallelValid, parallelReady, serialValid, serialReady;
  logic [9:0] adOut, hostAd, adWire, parallelData, serialWord;
  logic [9:0] lastAd = 10'h000;
  logic [5:0] codes[9] = '{6'h03, 6'h11, 6'h23, 6'h33, 6'h00, 6'h01, 6'h02, 6'h13, 6'h21};
  logic [9:0] expQ[$];
  int failures = 0;
  int checks = 0;
  int rdyMode = 1;
  int patIdx = 0;
  logic [5:0] curCode = 6'h03;
  logic smoothOn = 1'b0;
  logic [9:0] pY = 10'h000;
  logic [9:0] pCb = 10'h000;
  logic [9:0] pCr = 10'h000;
  // ******
  // clock, bus and design
  // ******
  // clock; the aux bus toggles when nobody drives it
  always #4 clk = ~clk;
  assign adWire = adOe ? adOut : (hostEn ? hostAd : ~lastAd);
  always @(posedge clk) lastAd <= adWire;
  vpg_self_test #(.LINE_WORDS(LW), .FIELD_LINES(8), .FIFO_DEPTH(32)) uut (.clk(clk), .rst(rst), .auxClk(auxClk),
    .auxSelectN(auxSelectN), .auxRdWr(auxRdWr), .adIn(adWire), .adOut(adOut), .adOe(adOe), .runPin(runPin),
    .runPinMapped(runPinMapped), .passOut(passOut), .parallelData(parallelData), .parallelValid(parallelValid),
    .parallelReady(parallelReady), .serialWord(serialWord), .serialValid(serialValid), .serialReady(serialReady));
  vpg_host_model host (.clk(clk), .auxClk(auxClk), .auxSelectN(auxSelectN), .auxRdWr(auxRdWr), .adDrive(hostAd),
    .adDriveEn(hostEn), .adWire(adWire));
  // serializer side: compares queued words, stalls as asked
  always @(posedge clk) begin
    if (serialValid === 1'b1 && serialReady === 1'b1) begin
      if (expQ.size() > 0) begin
        check("serialWord", expQ.pop_front(), serialWord);
      end else begin
        check("patternWord", pat_word(curCode, patIdx), serialWord);
        patIdx++;
      end
    end
    #1 serialReady = (rdyMode == 2) ? ($urandom % 4 != 0) : (rdyMode == 1);
  end
  // ******
  // tasks
  // ******
  // expected generator word at a run position; keeps its own smoothing history
  function automatic logic [9:0] pat_word(input logic [5:0] c, input int n);
    int w;
    int b;
    logic [9:0] e;
    w = n % LW;
    b = (w / (LW / 8) > 7) ? 7 : w / (LW / 8);
    case (c[1:0])
      2'h0: e = (w % 2 == 1) ? vpg_pkg::BLACK_Y : vpg_pkg::MID_C;
      2'h1: e = (w % 2 == 1) ? vpg_pkg::PLL_Y : vpg_pkg::MID_C;
      2'h2: e = (w % 2 == 1) ? vpg_pkg::EQ_Y : vpg_pkg::PATH_C;
      default: begin
        e = (w % 2 == 1) ? vpg_pkg::BAR_Y[b] : (w % 4 == 2) ? vpg_pkg::BAR_CR[b] : vpg_pkg::BAR_CB[b];
        if (smoothOn && b != 0 && w % (LW / 8) == 0) begin
          if (w % 2 == 1) e = 10'((11'(pY) + 11'(e)) >> 1);
          else if (w % 4 == 2) e = 10'((11'(pCr) + 11'(e)) >> 1);
          else e = 10'((11'(pCb) + 11'(e)) >> 1);
        end
      end
    endcase
    if (w % 2 == 1) pY = e;
    else if (w % 4 == 2) pCr = e;
    else pCb = e;
    return e;
  endfunction : pat_word
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task automatic check_reg(input logic [9:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.reg_read(addr, d);
    check("regRead", {2'h0, exp}, {2'h0, d});
  endtask : check_reg
  // waits for pass; a run that should pass and never does ends the test
  task automatic wait_pass(input logic exp);
    int k;
    for (k = 0; k < LIM && passOut !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (exp && k == LIM) begin
      failures++;
      finish_test();
    end else begin
      check("passOut", {9'h000, exp}, {9'h000, passOut});
    end
  endtask : wait_pass
  // offers one video word until taken; valid stays up for the caller
  task automatic send_word(input logic [9:0] w);
    int k;
    logic r;
    parallelData = w;
    parallelValid = 1'b1;
    r = 1'b0;
    for (k = 0; k < LIM && r !== 1'b1; k++) begin
      @(negedge clk);
      r = parallelReady;
      @(posedge clk);
    end
    #1 expQ.push_back(w);
    if (r !== 1'b1) begin
      failures++;
      finish_test();
    end
  endtask : send_word
  task automatic drain;
    rdyMode = 1;
    repeat (100) @(posedge clk);
    #1 check("serialValid", 10'h000, {9'h000, serialValid});
    patIdx = 0;
    pY = 10'h000;
    pCb = 10'h000;
    pCr = 10'h000;
  endtask : drain
  function automatic logic accepted(input logic [5:0] c);
    return c[5] ? (c[1:0] == 2'h3) : (c == 6'h03 || c == 6'h11);
  endfunction : accepted
  // ******
  // main sequence
  // ******
  initial begin
    void'($urandom(87));
    runPin = 1'b0;
    runPinMapped = 1'b1;
    parallelData = 10'h000;
    parallelValid = 1'b0;
    serialReady = 1'b1;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    @(posedge clk);
    #1 check("resetOut", 10'h000, {7'h00, adOe, passOut, serialValid});
    host.aux_init();
    check_reg(vpg_pkg::ADDR_SELFTEST, 8'h00);
    check_reg(vpg_pkg::ADDR_FORMAT_A, 8'h00);
    check_reg(10'h3ff, 8'h00);
    host.reg_write(vpg_pkg::ADDR_FORMAT_A, 10'h001);
    smoothOn = 1'b1;
    check_reg(vpg_pkg::ADDR_FORMAT_A, 8'h01);
    // fill the buffer while stalled, refuse one more, then drain in order
    rdyMode = 0;
    repeat (3) @(posedge clk);
    #1;
    for (int i = 0; i < 32; i++) send_word(10'($urandom));
    @(negedge clk);
    check("parallelReady", 10'h000, {9'h000, parallelReady});
    rdyMode = 2;
    @(posedge clk);
    #1 send_word(10'($urandom));
    parallelValid = 1'b0;
    for (int k = 0; k < LIM && expQ.size() > 0; k++) @(posedge clk);
    check("queueLeft", 10'h000, 10'(expQ.size()));
    // colour bars through the run pin
    host.reg_write(vpg_pkg::ADDR_SELFTEST, 10'h303);
    check_reg(vpg_pkg::ADDR_SELFTEST, 8'h03);
    runPin = 1'b1;
    wait_pass(1'b1);
    check_reg(vpg_pkg::ADDR_SELFTEST, 8'h83);
    runPin = 1'b0;
    drain();
    check("passHeld", 10'h001, {9'h000, passOut});
    // register run bit is overridden by the low pin, then obeyed
    host.reg_write(vpg_pkg::ADDR_SELFTEST, 10'h043);
    drain();
    runPinMapped = 1'b0;
    rdyMode = 2;
    wait_pass(1'b1);
    host.reg_write(vpg_pkg::ADDR_SELFTEST, 10'h003);
    drain();
    // every pattern type and standard, accepted or not
    for (int i = 0; i < 9; i++) begin
      curCode = codes[i];
      host.reg_write(vpg_pkg::ADDR_SELFTEST, {4'h0, codes[i]});
      host.reg_write(vpg_pkg::ADDR_SELFTEST, {4'h1, codes[i]});
      rdyMode = 2;
      wait_pass(accepted(codes[i]));
      check_reg(vpg_pkg::ADDR_SELFTEST, {accepted(codes[i]), 1'b1, codes[i]});
      host.reg_write(vpg_pkg::ADDR_SELFTEST, {4'h0, codes[i]});
      drain();
    end
    finish_test();
  end
endmodule : tb_top
